// [design/seb_front.sv]
/*
  Bus-facing front end of a serial eeprom acting as a two-wire slave.
  The link side samples the pins on LINK_CLK; power-up and write-cycle
  timing and the user byte ports sit on CLK. The memory array, address
  counter and page buffer live outside and answer RD_REQ within one bit for the first read byte, within one byte after.
*/
`default_nettype none

module seb_front
  import seb_pkg::*;
#(
  parameter int POWERUP_CYC = SEB_POWERUP_CYC,
  parameter int WRITE_CYC   = SEB_WRITE_CYC
) (
  // system clock, reset, enable
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // link sampling clock
  input  wire logic       LINK_CLK,
  // bus pins
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       ADDR_SELECT_LOW_PIN,
  input  wire logic       ADDR_SELECT_HIGH_PIN,
  input  wire logic       WP,
  // status
  output logic            READY,
  output logic            WRITE_BUSY,
  output logic            WRITE_START,
  // received bytes
  output logic            RX_VALID,
  output logic [7:0]      RX_DATA,
  output logic [1:0]      RX_INDEX,
  output logic            TOP_MEMORY_ADDRESS_BIT,
  // read data
  output logic            RD_REQ,
  input  wire logic       RD_VALID,
  input  wire logic [7:0] RD_DATA
);

  localparam int PCW = $clog2(POWERUP_CYC + 1);
  localparam int WCW = $clog2(WRITE_CYC + 1);

  // link reset: asserted at once, released on LINK_CLK
  logic [1:0] lrst_r;
  wire        lrst = lrst_r[1];

  always_ff @(posedge LINK_CLK or posedge RST)
    if (RST)
      lrst_r <= 2'b11;
    else
      lrst_r <= {lrst_r[0], 1'b0};

  // crossing wires
  logic lce;
  logic ready_s;
  logic busy_s;
  logic rdack_chg;
  logic wr_chg;
  logic rx_chg;
  logic rdreq_chg;
  logic scl_f;
  logic sda_f;
  logic sel_lo_f;
  logic sel_hi_f;
  logic wp_f;

  // link-side registers
  seb_state_t st_r;
  logic [3:0] bit_r;
  logic [1:0] idx_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] rd_buf_r;
  logic [7:0] rx_data_r;
  logic [1:0] rx_idx_r;
  logic       top_r;
  logic       rw_r;
  logic       oe_r;
  logic       mack_r;
  logic       wp_lock_r;
  logic       wr_ok_r;
  logic       wait_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       rx_tgl_r;
  logic       rd_tgl_r;
  logic       wr_tgl_r;

  // system-side registers
  logic [PCW-1:0] pu_cnt_r;
  logic [WCW-1:0] wr_cnt_r;
  logic           ready_r;
  logic           busy_r;
  logic           rd_pend_r;
  logic           rdack_tgl_r;
  logic [7:0]     rd_word_r;

  seb_xsync u_ce_x (
    .clk(LINK_CLK), .rst(lrst), .en(1'b1), .d(CE), .q(lce), .chg()
  );

  // pin sampling with glitch filters; select and protect idle low
  seb_pin_filter #(.STABLE(SEB_GLITCH_CYC), .INIT(1'b1)) u_scl_f (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .pin(SCL), .level(scl_f)
  );
  seb_pin_filter #(.STABLE(SEB_GLITCH_CYC), .INIT(1'b1)) u_sda_f (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .pin(SDA_IN), .level(sda_f)
  );
  seb_pin_filter #(.STABLE(SEB_GLITCH_CYC), .INIT(1'b0)) u_sel_lo_f (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .pin(ADDR_SELECT_LOW_PIN), .level(sel_lo_f)
  );
  seb_pin_filter #(.STABLE(SEB_GLITCH_CYC), .INIT(1'b0)) u_sel_hi_f (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .pin(ADDR_SELECT_HIGH_PIN), .level(sel_hi_f)
  );
  seb_pin_filter #(.STABLE(SEB_GLITCH_CYC), .INIT(1'b0)) u_wp_f (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .pin(WP), .level(wp_f)
  );

  // system to link crossings
  seb_xsync u_ready_x (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .d(ready_r), .q(ready_s), .chg()
  );
  seb_xsync u_busy_x (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .d(busy_r), .q(busy_s), .chg()
  );
  seb_xsync u_rdack_x (
    .clk(LINK_CLK), .rst(lrst), .en(lce), .d(rdack_tgl_r), .q(), .chg(rdack_chg)
  );

  // link to system crossings
  seb_xsync u_wr_x (
    .clk(CLK), .rst(RST), .en(CE), .d(wr_tgl_r), .q(), .chg(wr_chg)
  );
  seb_xsync u_rx_x (
    .clk(CLK), .rst(RST), .en(CE), .d(rx_tgl_r), .q(), .chg(rx_chg)
  );
  seb_xsync u_rdreq_x (
    .clk(CLK), .rst(RST), .en(CE), .d(rd_tgl_r), .q(), .chg(rdreq_chg)
  );

  // bus events from the filtered levels; the master makes them all
  wire scl_rise = scl_f && !scl_d_r;
  wire scl_fall = !scl_f && scl_d_r;
  wire start_ev = scl_f && scl_d_r && !sda_f && sda_d_r;
  wire stop_ev  = scl_f && scl_d_r && sda_f && !sda_d_r;
  wire byte_end = (bit_r == SEB_BIT_LAST);

  // address match: prefix, select pins, not busy, powered up
  wire pfx_hit  = (sh_r[SEB_PFX_HI:SEB_PFX_LO] == SEB_DEV_PREFIX);
  wire sel_hit  = (sh_r[SEB_SEL_HI:SEB_SEL_LO] == {sel_hi_f, sel_lo_f});
  wire addr_hit = pfx_hit && sel_hit && ready_s && !busy_s && !wait_r;
  wire wp_nack  = (idx_r == SEB_IDX_DATA) && wp_lock_r;

  // pin delay line for edge detection
  always_ff @(posedge LINK_CLK or posedge lrst)
    if (lrst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (lce)
    begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end

  // read data arrives from the system side by toggle handshake
  always_ff @(posedge LINK_CLK or posedge lrst)
    if (lrst)
      rd_buf_r <= SEB_RD_IDLE;
    else if (rdack_chg)
      rd_buf_r <= rd_word_r;

  // write-cycle handover: hold off until the system side shows busy
  always_ff @(posedge LINK_CLK or posedge lrst)
    if (lrst)
      wait_r <= 1'b0;
    else if (lce)
    begin
      if (stop_ev && wr_ok_r && !rw_r)
        wait_r <= 1'b1;
      else if (busy_s)
        wait_r <= 1'b0;
    end

  // slave engine: shift in on rise, drive after fall
  always_ff @(posedge LINK_CLK or posedge lrst)
    if (lrst)
    begin
      st_r      <= SEB_ST_IDLE;
      bit_r     <= '0;
      idx_r     <= SEB_IDX_DEV;
      sh_r      <= '0;
      tx_r      <= SEB_RD_IDLE;
      rx_data_r <= '0;
      rx_idx_r  <= SEB_IDX_DEV;
      top_r     <= 1'b0;
      rw_r      <= 1'b0;
      oe_r      <= 1'b0;
      mack_r    <= 1'b0;
      wp_lock_r <= 1'b0;
      wr_ok_r   <= 1'b0;
      rx_tgl_r  <= 1'b0;
      rd_tgl_r  <= 1'b0;
      wr_tgl_r  <= 1'b0;
    end
    else if (lce)
    begin
      if (start_ev)
      begin
        st_r      <= SEB_ST_DEVA;
        bit_r     <= '0;
        idx_r     <= SEB_IDX_DEV;
        oe_r      <= 1'b0;
        wp_lock_r <= 1'b0;
        wr_ok_r   <= 1'b0;
      end
      else if (stop_ev)
      begin
        st_r    <= SEB_ST_IDLE;
        oe_r    <= 1'b0;
        wr_ok_r <= 1'b0;
        if (wr_ok_r && !rw_r)
          wr_tgl_r <= ~wr_tgl_r;
      end
      else if (scl_rise)
      begin
        case (st_r)
          SEB_ST_DEVA, SEB_ST_RXB:
          begin
            sh_r  <= {sh_r[6:0], sda_f};
            bit_r <= bit_r + 1'b1;
          end
          SEB_ST_TXB:
            bit_r <= bit_r + 1'b1;
          SEB_ST_MACK:
            mack_r <= !sda_f;
          default:
            mack_r <= mack_r;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_r)
          SEB_ST_DEVA:
            if (byte_end)
            begin
              if (addr_hit)
              begin
                oe_r  <= 1'b1;
                st_r  <= SEB_ST_ACK;
                rw_r  <= sh_r[SEB_RW_BIT];
                top_r <= sh_r[SEB_TOP_BIT];
                if (sh_r[SEB_RW_BIT])
                  rd_tgl_r <= ~rd_tgl_r;                   // prefetch first byte
              end
              else
                st_r <= SEB_ST_IDLE;
            end
          SEB_ST_RXB:
            if (byte_end)
            begin
              if (wp_nack)
                st_r <= SEB_ST_IDLE;
              else
              begin
                oe_r      <= 1'b1;
                st_r      <= SEB_ST_ACK;
                rx_data_r <= sh_r;
                rx_idx_r  <= idx_r;
                rx_tgl_r  <= ~rx_tgl_r;
                if (idx_r == SEB_IDX_DATA)
                  wr_ok_r <= 1'b1;
              end
            end
          SEB_ST_ACK:
          begin
            bit_r <= '0;
            if (rw_r)
            begin
              tx_r     <= rd_buf_r;
              oe_r     <= !rd_buf_r[7];
              st_r     <= SEB_ST_TXB;
              rd_tgl_r <= ~rd_tgl_r;
            end
            else
            begin
              oe_r <= 1'b0;
              st_r <= SEB_ST_RXB;
              if (idx_r == SEB_IDX_LO)
                wp_lock_r <= wp_f;
              if (idx_r != SEB_IDX_DATA)
                idx_r <= idx_r + 1'b1;
            end
          end
          SEB_ST_TXB:
            if (byte_end)
            begin
              oe_r <= 1'b0;                                // release for master ack
              st_r <= SEB_ST_MACK;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b1};
              oe_r <= !tx_r[6];
            end
          SEB_ST_MACK:
          begin
            bit_r <= '0;
            if (mack_r)
            begin
              tx_r     <= rd_buf_r;
              oe_r     <= !rd_buf_r[7];
              st_r     <= SEB_ST_TXB;
              rd_tgl_r <= ~rd_tgl_r;
            end
            else
              st_r <= SEB_ST_IDLE;
          end
          default:
            oe_r <= 1'b0;
        endcase
      end
    end

  assign SDA_OUT = 1'b0;
  assign SDA_OE  = oe_r;

  // power-up timer: ready once the delay has run after reset
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      pu_cnt_r <= '0;
      ready_r  <= 1'b0;
    end
    else if (CE && !ready_r)
    begin
      if (pu_cnt_r == PCW'(POWERUP_CYC - 1))
        ready_r <= 1'b1;
      else
        pu_cnt_r <= pu_cnt_r + 1'b1;
    end

  // internal write cycle of fixed length
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      wr_cnt_r    <= '0;
      busy_r      <= 1'b0;
      WRITE_START <= 1'b0;
    end
    else if (CE)
    begin
      WRITE_START <= wr_chg && !busy_r;
      if (wr_chg && !busy_r)
      begin
        busy_r   <= 1'b1;
        wr_cnt_r <= '0;
      end
      else if (busy_r)
      begin
        if (wr_cnt_r == WCW'(WRITE_CYC - 1))
          busy_r <= 1'b0;
        else
          wr_cnt_r <= wr_cnt_r + 1'b1;
      end
    end

  // received bytes: link data is stable for a whole byte after the toggle
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      RX_VALID               <= 1'b0;
      RX_DATA                <= '0;
      RX_INDEX               <= SEB_IDX_DEV;
      TOP_MEMORY_ADDRESS_BIT <= 1'b0;
    end
    else if (CE)
    begin
      RX_VALID <= rx_chg;
      if (rx_chg)
      begin
        RX_DATA                <= rx_data_r;
        RX_INDEX               <= rx_idx_r;
        TOP_MEMORY_ADDRESS_BIT <= top_r;
      end
    end

  // read requests: one pulse out, first valid word returned
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      RD_REQ      <= 1'b0;
      rd_pend_r   <= 1'b0;
      rd_word_r   <= SEB_RD_IDLE;
      rdack_tgl_r <= 1'b0;
    end
    else if (CE)
    begin
      RD_REQ <= rdreq_chg;
      if (rdreq_chg)
        rd_pend_r <= 1'b1;
      else if (rd_pend_r && RD_VALID)
      begin
        rd_pend_r   <= 1'b0;
        rd_word_r   <= RD_DATA;
        rdack_tgl_r <= ~rdack_tgl_r;
      end
    end

  assign READY      = ready_r;
  assign WRITE_BUSY = busy_r;

endmodule : seb_front

`default_nettype wire

// [design/seb_pin_filter.sv]
/*
  Three-flop input synchroniser with a stability filter for one pin.
  Assumes clk samples the pin asynchronously; output moves only after
  the second and third flops agree for STABLE cycles.
*/
`default_nettype none

module seb_pin_filter #(
  parameter int   STABLE = 1,
  parameter logic INIT   = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);

  localparam int CW = (STABLE < 2) ? 1 : $clog2(STABLE);

  logic          s1_r;
  logic          s2_r;
  logic          s3_r;
  logic [CW-1:0] cnt_r;
  wire           agree = (s2_r == s3_r);

  // three-flop chain; only s2 and s3 are compared
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else if (en)
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end

  // pulses shorter than the filter window never reach the output
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      level <= INIT;
      cnt_r <= '0;
    end
    else if (en)
    begin
      if (!agree || s3_r == level)
        cnt_r <= '0;
      else if (cnt_r == CW'(STABLE - 1))
      begin
        level <= s3_r;
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end

endmodule : seb_pin_filter

`default_nettype wire

// [design/seb_pkg.sv]
/*
  Shared constants for the serial eeprom bus front end: device address
  layout, byte indices, bit counts and timing figures with derived counts.
  Assumes a 4 ns system clock and a 160 ns link sampling clock.
*/
`default_nettype none

package seb_pkg;

  // device address byte layout
  localparam logic [3:0] SEB_DEV_PREFIX = 4'hA;   // fixed prefix 1010
  localparam int         SEB_PFX_HI     = 7;
  localparam int         SEB_PFX_LO     = 4;
  localparam int         SEB_SEL_HI     = 3;
  localparam int         SEB_SEL_LO     = 2;
  localparam int         SEB_TOP_BIT    = 1;
  localparam int         SEB_RW_BIT     = 0;

  // byte index within a transfer
  localparam logic [1:0] SEB_IDX_DEV  = 2'h0;
  localparam logic [1:0] SEB_IDX_HI   = 2'h1;
  localparam logic [1:0] SEB_IDX_LO   = 2'h2;
  localparam logic [1:0] SEB_IDX_DATA = 2'h3;

  localparam logic [3:0] SEB_BIT_LAST = 4'h8;     // eight data bits, ninth clock is ack
  localparam logic [7:0] SEB_RD_IDLE  = 8'hFF;    // released line reads as ones

  // clocks
  localparam int SEB_CLK_PERIOD_NS  = 4;
  localparam int SEB_LINK_PERIOD_NS = 160;

  // timing figures and derived cycle counts
  localparam int  SEB_GLITCH_FILTER_WIDTH_NS = 50;
  localparam real SEB_POWERUP_READY_DELAY_MS = 0.1;
  localparam real SEB_INTERNAL_WRITE_TIME_MS = 5.0;
  localparam int  SEB_GLITCH_CYC_RAW =
    (SEB_GLITCH_FILTER_WIDTH_NS + SEB_LINK_PERIOD_NS - 1) / SEB_LINK_PERIOD_NS;
  localparam int  SEB_GLITCH_CYC = (SEB_GLITCH_CYC_RAW < 1) ? 1 : SEB_GLITCH_CYC_RAW;
  localparam int  SEB_POWERUP_CYC =
    $rtoi(SEB_POWERUP_READY_DELAY_MS * 1.0e6 / SEB_CLK_PERIOD_NS);
  localparam int  SEB_WRITE_CYC =
    $rtoi(SEB_INTERNAL_WRITE_TIME_MS * 1.0e6 / SEB_CLK_PERIOD_NS);

  // link state machine, gray steps along the write path
  typedef enum logic [2:0] {
    SEB_ST_IDLE = 3'h0,
    SEB_ST_DEVA = 3'h1,
    SEB_ST_ACK  = 3'h3,
    SEB_ST_RXB  = 3'h2,
    SEB_ST_TXB  = 3'h6,
    SEB_ST_MACK = 3'h7
  } seb_state_t;

endpackage : seb_pkg

`default_nettype wire

// [design/seb_xsync.sv]
/*
  Two-flop level synchroniser with a change pulse, used for levels and
  for toggle-coded events crossing between the system and link clocks.
*/
`default_nettype none

module seb_xsync (
  // clock and reset of the receiving side
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  // foreign level and its local copy
  input  wire logic d,
  output logic      q,
  output logic      chg
);

  logic m_r;
  logic q_r;
  logic p_r;

  // first flop feeds only the second
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      m_r <= 1'b0;
      q_r <= 1'b0;
      p_r <= 1'b0;
    end
    else if (en)
    begin
      m_r <= d;
      q_r <= m_r;
      p_r <= q_r;
    end

  assign q   = q_r;
  assign chg = en && (q_r != p_r);

endmodule : seb_xsync

`default_nettype wire

// [testbench/seb_front_asserts.sv]
/*
  Concurrent checks on the ports of the eeprom bus front end.
  Assumes it is bound to seb_front and sees only that module's ports.
*/
`default_nettype none

module seb_front_asserts
  import seb_pkg::*;
#(
  parameter int POWERUP_CYC = SEB_POWERUP_CYC,
  parameter int WRITE_CYC   = SEB_WRITE_CYC
) (
  // clocks and reset
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       LINK_CLK,
  // bus pins
  input wire logic       SCL,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  // status and user side
  input wire logic       READY,
  input wire logic       WRITE_BUSY,
  input wire logic       WRITE_START,
  input wire logic       RX_VALID,
  input wire logic [1:0] RX_INDEX,
  input wire logic       RD_REQ
);
  timeunit 1ns;
  timeprecision 1ps;

  int since_rst_r;
  int busy_run_r;

  // cycles since reset release and length of the current busy spell
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      since_rst_r <= 0;
      busy_run_r  <= 0;
    end
    else
    begin
      since_rst_r <= (since_rst_r < 1000000) ? since_rst_r + 1 : since_rst_r;
      busy_run_r  <= WRITE_BUSY ? busy_run_r + 1 : 0;
    end
  end

  property p_open_drain;
    @(posedge CLK) disable iff (RST) SDA_OUT == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_ready_late;
    @(posedge CLK) disable iff (RST) READY |-> since_rst_r >= POWERUP_CYC - 1;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  property p_ready_due;
    @(posedge CLK) disable iff (RST) since_rst_r >= POWERUP_CYC + 2 |-> READY;
  endproperty
  a_ready_due: assert property (p_ready_due) else $error("ready too late");
  property p_pull_low_phase;
    @(posedge LINK_CLK) disable iff (RST) $rose(SDA_OE) |-> !SCL;
  endproperty
  a_pull_low_phase: assert property (p_pull_low_phase) else $error("pull while clock high");
  property p_no_ack_busy;
    @(posedge LINK_CLK) disable iff (RST) $rose(SDA_OE) |-> !WRITE_BUSY;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("pull during write");
  property p_busy_quiet;
    @(posedge CLK) disable iff (RST) WRITE_BUSY |-> !RX_VALID && !RD_REQ;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("traffic during write");
  property p_start_busy;
    @(posedge CLK) disable iff (RST) WRITE_START |-> ##[0:1] WRITE_BUSY;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_cause;
    @(posedge CLK) disable iff (RST) $rose(WRITE_BUSY) |-> WRITE_START || $past(WRITE_START);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_busy_len;
    @(posedge CLK) disable iff (RST) busy_run_r <= WRITE_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
  property p_rx_pulse;
    @(posedge CLK) disable iff (RST) RX_VALID |-> RX_INDEX != SEB_IDX_DEV ##1 !RX_VALID;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("bad received byte pulse");
  property p_rd_pulse;
    @(posedge CLK) disable iff (RST) RD_REQ |=> !RD_REQ;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");

  c_write: cover property (@(posedge CLK) disable iff (RST) WRITE_START);
  c_data: cover property (@(posedge CLK) disable iff (RST) RX_VALID && RX_INDEX == SEB_IDX_DATA);
  c_read: cover property (@(posedge CLK) disable iff (RST) RD_REQ);
endmodule : seb_front_asserts

bind seb_front seb_front_asserts #(.POWERUP_CYC(POWERUP_CYC), .WRITE_CYC(WRITE_CYC)) i_chk (
  .CLK(CLK), .RST(RST), .LINK_CLK(LINK_CLK), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .READY(READY), .WRITE_BUSY(WRITE_BUSY), .WRITE_START(WRITE_START), .RX_VALID(RX_VALID),
  .RX_INDEX(RX_INDEX), .RD_REQ(RD_REQ));

`default_nettype wire

// [testbench/seb_front_bench.sv]
/*
  Self-checking bench for the eeprom bus front end: power-up, address
  match, write, busy polling, write protect and read.
  Assumes the master model, the bound checker and shortened counts.
*/
`default_nettype none

module seb_front_bench
  import seb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PU_CYC = 50;      // shortened power-up delay
  localparam int WR_CYC = 10000;   // shortened write time, outlasts one poll
  localparam int LIMIT  = 100000;  // run ceiling in system cycles

  logic            clk      = 1'b0;
  logic            link_clk = 1'b0;
  logic            rst      = 1'b1;
  logic            ce       = 1'b1;
  logic            a_lo     = 1'b0;
  logic            a_hi     = 1'b0;
  logic            wp       = 1'b0;
  logic            rd_valid = 1'b0;
  logic [7:0]      rd_data  = 8'h00;
  logic            glitch   = 1'b0;    // short noise pulse on the data wire
  wire logic       scl, sda_low, sda_line, sda_out, sda_oe, ready, write_busy, write_start;
  wire logic       rx_valid, top_bit, rd_req;
  wire logic [7:0] rx_data;
  wire logic [1:0] rx_index;
  logic [7:0]      rx_seen [4];
  logic            top_seen;
  int              starts = 0, busy_len = 0, cyc = 0, bad_count = 0, n_compared = 0;

  // system clock and an unrelated link clock
  always #2 clk = ~clk;
  initial
  begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  // pulled-up open-drain data wire
  assign sda_line = !(sda_low || glitch || (sda_oe && !sda_out));

  seb_front #(.POWERUP_CYC(PU_CYC), .WRITE_CYC(WR_CYC)) i_dut (
    .CLK(clk), .RST(rst), .CE(ce), .LINK_CLK(link_clk), .SCL(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_LOW_PIN(a_lo),
    .ADDR_SELECT_HIGH_PIN(a_hi), .WP(wp), .READY(ready), .WRITE_BUSY(write_busy),
    .WRITE_START(write_start), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_INDEX(rx_index),
    .TOP_MEMORY_ADDRESS_BIT(top_bit), .RD_REQ(rd_req), .RD_VALID(rd_valid),
    .RD_DATA(rd_data));

  seb_master_model i_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // memory side answers a read request one cycle later
  always @(posedge clk)
  begin
    rd_valid <= rd_req;
    rd_data  <= rd_req ? 8'h96 : ~rd_data;
  end

  // capture bytes, count write starts and busy cycles, cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1)
    begin
      rx_seen[rx_index] <= rx_data;
      top_seen          <= top_bit;
    end
    if (write_start === 1'b1)
      starts <= starts + 1;
    if (write_busy === 1'b1)
      busy_len <= busy_len + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_byte

  function automatic logic [7:0] dev_byte(input logic [1:0] sel, input logic top,
                                          input logic rd);
    return {SEB_DEV_PREFIX, sel, top, rd};
  endfunction : dev_byte

  // one byte out; the expected line level at the ninth clock is 0 for ack
  task automatic send(input logic [7:0] b, input logic exp_line, input string what);
    logic [7:0] rx;
    logic       ack;
    i_master.xfer(b, 1'b1, rx, ack);
    check_bit(ack, exp_line, what);
  endtask : send

  task automatic t_powerup();
    int n;
    n = 0;
    check_bit(ready, 1'b0, "ready in reset");
    check_bit(sda_oe, 1'b0, "pull in reset");
    rst <= 1'b0;
    while (ready !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(n >= PU_CYC - 1 && n <= PU_CYC + 2, 1'b1, "power-up delay");
  endtask : t_powerup

  task automatic t_wrong();
    @(posedge clk);
    a_hi <= 1'b1;
    i_master.start_cond();
    send(dev_byte(2'b01, 1'b0, 1'b0), 1'b1, "foreign select bits");
    i_master.stop_cond();
  endtask : t_wrong

  task automatic t_write();
    i_master.start_cond();
    send(dev_byte(2'b10, 1'b1, 1'b0), 1'b0, "write address");
    send(8'h3C, 1'b0, "high address");
    send(8'hC3, 1'b0, "low address");
    send(8'hA5, 1'b0, "data byte");
    i_master.stop_cond();
    @(negedge clk);
    check_byte(rx_seen[SEB_IDX_HI], 8'h3C, "high address byte");
    check_byte(rx_seen[SEB_IDX_LO], 8'hC3, "low address byte");
    check_byte(rx_seen[SEB_IDX_DATA], 8'hA5, "data byte value");
    check_bit(top_seen, 1'b1, "top address bit");
    check_bit(starts == 1, 1'b1, "write started");
  endtask : t_write

  task automatic t_poll();
    int n;
    n = 0;
    i_master.start_cond();
    send(dev_byte(2'b10, 1'b0, 1'b0), 1'b1, "address while busy");
    i_master.stop_cond();
    @(negedge clk);
    while (write_busy === 1'b1 && n < WR_CYC)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(busy_len == WR_CYC, 1'b1, "write cycle length");
  endtask : t_poll

  task automatic t_wp();
    @(posedge clk);
    wp <= 1'b1;
    i_master.start_cond();
    send(dev_byte(2'b10, 1'b0, 1'b0), 1'b0, "protected address");
    send(8'h01, 1'b0, "protected high");
    send(8'h02, 1'b0, "protected low");
    send(8'h5A, 1'b1, "protected data");
    i_master.stop_cond();
    wp <= 1'b0;
    @(negedge clk);
    check_bit(starts == 1 && write_busy === 1'b0, 1'b1, "protected write");
  endtask : t_wp

  task automatic t_read();
    logic [7:0] rx;
    logic       ack;
    i_master.start_cond();
    send(dev_byte(2'b10, 1'b0, 1'b1), 1'b0, "read address");
    // a 40 ns low pulse while the clock is high must not look like a start
    fork
      i_master.xfer(8'hFF, 1'b0, rx, ack);
      begin
        repeat (450) @(posedge clk);
        glitch <= 1'b1;
        repeat (10) @(posedge clk);
        glitch <= 1'b0;
      end
    join
    check_byte(rx, 8'h96, "glitched read byte");
    i_master.xfer(8'hFF, 1'b1, rx, ack);
    i_master.stop_cond();
    check_byte(rx, 8'h96, "read data");
  endtask : t_read

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // reset long enough for the link domain, then the scenarios in turn
  initial
  begin
    repeat (128) @(posedge clk);
    t_powerup();
    t_wrong();
    t_write();
    t_poll();
    t_wp();
    t_read();
    tally_and_finish();
  end
endmodule : seb_front_bench

`default_nettype wire

// [testbench/seb_master_model.sv]
/*
  Behavioural two-wire bus master: clock, start, stop, bytes MSB first.
  Assumes a pulled-up data wire resolved outside and one caller at a time.
*/
`default_nettype none

module seb_master_model (
  // timebase
  input  wire logic clk,
  // resolved data wire
  input  wire logic sda_line,
  // driven pins
  output var logic  scl,
  output var logic  sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int QTR = 165;  // quarter bit, over four link cycles

  // bus idles released with the clock high
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause

  // data moves mid low phase, is sampled late in the high phase
  task automatic put_bit(input logic b, output logic seen);
    pause(QTR);
    sda_low <= ~b;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    seen = sda_line;
    scl <= 1'b0;
  endtask : put_bit

  task automatic start_cond();
    pause(QTR);
    sda_low <= 1'b0;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    sda_low <= 1'b1;
    pause(2 * QTR);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    pause(QTR);
    sda_low <= 1'b1;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    sda_low <= 1'b0;
    pause(2 * QTR);
  endtask : stop_cond

  // eight bits then the ninth clock; ack_in high releases the line
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack_out);
  endtask : xfer
endmodule : seb_master_model

`default_nettype wire
